// ==== design/option_regs_dtr_filter.sv ====
// module: option register bank with dtr change-of-state persistence filter
// interfaces
// write side: restore, direct write and field command share one answer path;
//   in one cycle only the first of restore, direct write, field command acts,
//   and the others are dropped without a flag.
// every accepted or refused request is answered one cycle later by a single
//   pulse on cmd_done_q or cmd_err_q, with the option outputs updated alongside.
// read side: rd_done_q, rd_hit_q and rd_data_q follow rd_valid by one cycle;
//   a read meeting a write in the same cycle returns the value before the write.
// dtr_in is taken as synchronous to clk; no synchroniser is fitted, so a lead
//   coming straight from a connector must be synchronised before this block.
// the tick length is a parameter so that simulation can run with short ticks;
//   the default gives 10 ms at a 100 MHz clock.
// factory restore leaves installation alone; only reset returns it to zero.
// speed codes 1 and 7 are stored as written and flagged through speed_valid_q.
`timescale 1ns/1ps
module option_regs_dtr_filter
	import option_regs_pkg::*;
#(
	parameter int TICK_CYCLES = DTR_TICK_CYCLES
) (
	// clock and reset
	input  wire logic          clk,
	input  wire logic          resetn,
	// direct register write
	input  wire logic          reg_wr_valid,
	input  wire reg_write_t    reg_wr,
	// field commands
	input  wire logic          field_valid,
	input  wire field_write_t  field_wr,
	// restore factory defaults
	input  wire logic          factory_restore,
	// register read
	input  wire logic          rd_valid,
	input  wire logic [7:0]    rd_regnum,
	output logic               rd_done_q,
	output logic               rd_hit_q,
	output logic [7:0]         rd_data_q,
	// command completion
	output logic               cmd_done_q,
	output logic               cmd_err_q,
	// option outputs
	output speaker_result_t    speaker_result_q,
	output line_options_t      line_options_q,
	output installation_t      installation_q,
	output logic [7:0]         dtr_time_q,
	output logic               speed_valid_q,
	// dtr lead
	input  wire logic          dtr_in,
	output logic               dtr_ack_q,
	output logic               dtr_change_q
);

	// ****************************************************************
	// parameter checks
	// ****************************************************************
	// the tick divider cannot count a period shorter than two cycles;
	// a shorter tick would also make the restart of the divider meaningless,
	// so such values are refused here rather than left to misbehave
	if (TICK_CYCLES < 2) begin : g_bad_tick_cycles
		$error("option_regs_dtr_filter: TICK_CYCLES must be at least 2");
	end

	// ****************************************************************
	// decode helpers
	// ****************************************************************
	// one place for the map, so the read hit flag matches the write case
	function automatic logic is_mapped(input logic [7:0] regnum);
		is_mapped = (regnum == REG_SPEAKER_RESULT) || (regnum == REG_LINE_OPTIONS) ||
			(regnum == REG_INSTALLATION) || (regnum == REG_DTR_TIME);
	endfunction

	function automatic logic speed_ok(input logic [2:0] code);
		speed_ok = (code != SPEED_UNUSED_LO) && (code != SPEED_UNUSED_HI);
	endfunction

	// ****************************************************************
	// option registers
	// ****************************************************************
	speaker_result_t spk_d;
	line_options_t   line_d;
	installation_t   inst_d;
	logic [7:0]      dtr_time_d;
	logic            speed_valid_d;
	logic            cmd_done_d;
	logic            cmd_err_d;
	logic            arg_ok;

	// argument range check for the field commands; a refused argument is
	// flagged rather than truncated, since a silently clipped value would
	// leave the terminal believing a setting it never got
	always_comb begin
		arg_ok = 1'b0;
		case (field_wr.cmd)
			CMD_VOLUME:       arg_ok = (field_wr.arg <= MAX_ARG_2BIT);
			CMD_SPEAKER_CTRL: arg_ok = (field_wr.arg <= MAX_ARG_2BIT);
			CMD_RESULT_CODE:  arg_ok = (field_wr.arg <= MAX_ARG_3BIT);
			CMD_DIAL_RATIO:   arg_ok = (field_wr.arg <= MAX_ARG_1BIT);
			CMD_REMOTE_LOOP:  arg_ok = (field_wr.arg <= MAX_ARG_1BIT);
			CMD_GUARD_TONE:   arg_ok = (field_wr.arg <= MAX_ARG_2BIT);
			default:          arg_ok = 1'b0;
		endcase
	end

	// priority: factory restore, then direct write, then field command
	// the field commands never reach installation, which only a direct write may set
	always_comb begin
		spk_d      = speaker_result_q;
		line_d     = line_options_q;
		inst_d     = installation_q;
		dtr_time_d = dtr_time_q;
		cmd_done_d = 1'b0;
		cmd_err_d  = 1'b0;
		if (factory_restore) begin
			spk_d      = speaker_result_t'(RST_SPEAKER_RESULT);
			line_d     = line_options_t'(RST_LINE_OPTIONS);
			dtr_time_d = RST_DTR_TIME;
			cmd_done_d = 1'b1; // installation left as is
		end else if (reg_wr_valid) begin
			cmd_done_d = 1'b1;
			case (reg_wr.regnum)
				// any byte is accepted, fields stored verbatim
				REG_SPEAKER_RESULT: spk_d = speaker_result_t'(reg_wr.value);
				// any byte accepted, unused speed codes stored as written
				REG_LINE_OPTIONS:   line_d = line_options_t'(reg_wr.value);
				// only path that reaches installation; bit 3 masked
				REG_INSTALLATION:   inst_d = installation_t'(reg_wr.value & INST_WRITE_MASK);
				// full 0..255 range
				REG_DTR_TIME:       dtr_time_d = reg_wr.value;
				default: begin
					cmd_done_d = 1'b0;
					cmd_err_d  = 1'b1; // unmapped register number
				end
			endcase
		end else if (field_valid) begin
			if (!arg_ok) begin
				cmd_err_d = 1'b1; // out-of-range argument leaves fields unchanged
			end else begin
				cmd_done_d = 1'b1;
				case (field_wr.cmd)
					CMD_VOLUME:       spk_d.speaker_volume = field_wr.arg[1:0];
					CMD_SPEAKER_CTRL: spk_d.speaker_ctrl = field_wr.arg[1:0];
					CMD_RESULT_CODE:  spk_d.result_code = field_wr.arg[2:0];
					CMD_DIAL_RATIO:   spk_d.make_break_ratio = field_wr.arg[0];
					CMD_REMOTE_LOOP:  line_d.remote_loop_en = field_wr.arg[0];
					CMD_GUARD_TONE:   line_d.guard_tone = field_wr.arg[1:0];
					default: begin
						cmd_done_d = 1'b0;
						cmd_err_d  = 1'b1;
					end
				endcase
			end
		end
		// unused bit can never become one, whatever path wrote it
		inst_d.unused = 1'b0;
		// speed code flagged as usable only for the defined codes
		// unused codes are still stored, so a read returns what was written
		speed_valid_d = speed_ok(line_d.speed);
	end

	// reset takes the factory values, installation included; the reset constants
	// other than RST_INSTALLATION double as the restore values, so the two can never drift apart
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			speaker_result_q <= speaker_result_t'(RST_SPEAKER_RESULT);
			line_options_q   <= line_options_t'(RST_LINE_OPTIONS);
			installation_q   <= installation_t'(RST_INSTALLATION);
			dtr_time_q       <= RST_DTR_TIME;
			speed_valid_q    <= 1'b1;
			cmd_done_q       <= 1'b0;
			cmd_err_q        <= 1'b0;
		end else begin
			speaker_result_q <= spk_d;
			line_options_q   <= line_d; // parity bits 5:4 drive no logic here
			installation_q   <= inst_d; // bits 0..2, 4..7 go out as options
			dtr_time_q       <= dtr_time_d;
			speed_valid_q    <= speed_valid_d;
			cmd_done_q       <= cmd_done_d;
			cmd_err_q        <= cmd_err_d;
		end
	end

	// ****************************************************************
	// register read
	// ****************************************************************
	logic       rd_done_d;
	logic       rd_hit_d;
	logic [7:0] rd_data_d;

	// reads see the stored value, not a write landing in the same cycle
	// data is zero when no read is pending, so several banks can share an or-ed bus
	always_comb begin
		rd_done_d = rd_valid;
		rd_hit_d  = rd_valid && is_mapped(rd_regnum);
		rd_data_d = 8'h00;
		if (rd_valid) begin
			case (rd_regnum)
				REG_SPEAKER_RESULT: rd_data_d = speaker_result_q;
				REG_LINE_OPTIONS:   rd_data_d = line_options_q;
				REG_INSTALLATION:   rd_data_d = installation_q; // bit 3 is zero
				REG_DTR_TIME:       rd_data_d = dtr_time_q;
				default:            rd_data_d = 8'h00;
			endcase
		end
	end

	// answer flops; rd_done_q pulses for exactly one cycle per request
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rd_done_q <= 1'b0;
			rd_hit_q  <= 1'b0;
			rd_data_q <= 8'h00;
		end else begin
			rd_done_q <= rd_done_d;
			rd_hit_q  <= rd_hit_d;
			rd_data_q <= rd_data_d;
		end
	end

	// ****************************************************************
	// dtr persistence filter
	// ****************************************************************
	logic       dtr_tick;
	logic       dtr_differs;
	logic [7:0] persist_q;
	logic [7:0] persist_d;
	logic       dtr_ack_d;
	logic       dtr_change_d;

	// timing, with N the stored time and T the tick length in cycles: the first
	// tick lands T cycles after the lead starts to differ, the count reaches N
	// after N ticks and the acknowledge follows about two cycles later
	// N of zero acknowledges on the cycle after the change
	// trade-off: one divider restarted per change keeps the logic small, at the
	// price of whole-tick resolution on the persistence time
	// the lead differs from the acknowledged level while a change is pending
	assign dtr_differs = (dtr_in != dtr_ack_q);

	// divider is held while the lead agrees, so each change gets full ticks
	// the tick is registered, so it trails the divider wrap by one cycle
	dtr_tick_gen #(
		.TICK_CYCLES (TICK_CYCLES)
	) i_dtr_tick_gen (
		.clk     (clk),
		.resetn  (resetn),
		.restart (!dtr_differs),
		.tick_q  (dtr_tick)
	);

	// counts whole ticks of a differing level; a return resets it
	always_comb begin
		persist_d    = persist_q;
		dtr_ack_d    = dtr_ack_q;
		dtr_change_d = 1'b0;
		if (!dtr_differs) begin
			persist_d = 8'h00;
		end else if (persist_q >= dtr_time_q) begin
			// a shortened time mid-count takes effect at once
			dtr_ack_d    = dtr_in;
			dtr_change_d = 1'b1;
			persist_d    = 8'h00;
		end else if (dtr_tick) begin
			persist_d = persist_q + 8'h01;
		end
	end

	// the acknowledged level starts off after reset, whatever the lead shows;
	// a lead already on at release is then filtered like any other change
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			persist_q    <= 8'h00;
			dtr_ack_q    <= 1'b0;
			dtr_change_q <= 1'b0;
		end else begin
			persist_q    <= persist_d;
			dtr_ack_q    <= dtr_ack_d;
			dtr_change_q <= dtr_change_d;
		end
	end

endmodule

// ==== design/option_regs_pkg.sv ====
// package: register numbers, layouts, reset values, commands and timing for the option bank
package option_regs_pkg;

	// ****************************************************************
	// register numbers used by the direct register write command
	// ****************************************************************
	localparam logic [7:0] REG_SPEAKER_RESULT = 8'h16; // register 22
	localparam logic [7:0] REG_LINE_OPTIONS   = 8'h17; // register 23
	localparam logic [7:0] REG_INSTALLATION   = 8'h18; // register 24
	localparam logic [7:0] REG_DTR_TIME       = 8'h19; // register 25

	// ****************************************************************
	// values after reset, and after factory defaults for all but installation
	// ****************************************************************
	localparam logic [7:0] RST_SPEAKER_RESULT = 8'h76;
	localparam logic [7:0] RST_LINE_OPTIONS   = 8'h07;
	localparam logic [7:0] RST_INSTALLATION   = 8'h00;
	localparam logic [7:0] RST_DTR_TIME       = 8'h05;

	// ****************************************************************
	// field positions and argument limits
	// ****************************************************************
	localparam int          POS_VOLUME       = 0;
	localparam int          POS_SPK_CTRL     = 2;
	localparam int          POS_RESULT       = 4;
	localparam int          POS_RATIO        = 7;
	localparam int          POS_REMOTE_LOOP  = 0;
	localparam int          POS_SPEED        = 1;
	localparam int          POS_PARITY       = 4;
	localparam int          POS_GUARD        = 6;
	localparam int          POS_INST_UNUSED  = 3;
	localparam logic [7:0]  INST_WRITE_MASK  = 8'hf7;
	localparam logic [7:0]  MAX_ARG_2BIT     = 8'h03;
	localparam logic [7:0]  MAX_ARG_3BIT     = 8'h07;
	localparam logic [7:0]  MAX_ARG_1BIT     = 8'h01;
	localparam logic [2:0]  SPEED_UNUSED_LO  = 3'h1;
	localparam logic [2:0]  SPEED_UNUSED_HI  = 3'h7;

	// ****************************************************************
	// dtr persistence timing
	// ****************************************************************
	localparam int DTR_TICK_MS     = 10;
	localparam int CLK_FREQ_KHZ    = 100000;
	localparam int DTR_TICK_CYCLES = DTR_TICK_MS * CLK_FREQ_KHZ;

	// ****************************************************************
	// field commands from the terminal side
	// ****************************************************************
	typedef enum logic [2:0] {
		CMD_VOLUME,
		CMD_SPEAKER_CTRL,
		CMD_RESULT_CODE,
		CMD_DIAL_RATIO,
		CMD_REMOTE_LOOP,
		CMD_GUARD_TONE
	} field_cmd_t;

	// ****************************************************************
	// register layouts, msb first
	// ****************************************************************
	typedef struct packed {
		logic       make_break_ratio;
		logic [2:0] result_code;
		logic [1:0] speaker_ctrl;
		logic [1:0] speaker_volume;
	} speaker_result_t;

	typedef struct packed {
		logic [1:0] guard_tone;
		logic [1:0] parity;
		logic [2:0] speed;
		logic       remote_loop_en;
	} line_options_t;

	typedef struct packed {
		logic make_busy_local;
		logic speakerphone_off;
		logic delay_speakerphone;
		logic data_metering;
		logic unused;
		logic internal_dtmf;
		logic a_law;
		logic no_telephone;
	} installation_t;

	typedef struct packed {
		logic [7:0] regnum;
		logic [7:0] value;
	} reg_write_t;

	typedef struct packed {
		field_cmd_t cmd;
		logic [7:0] arg;
	} field_write_t;

endpackage

// ==== design/dtr_tick_gen.sv ====
// module: restartable 10 ms tick divider for the dtr persistence filter
`timescale 1ns/1ps
module dtr_tick_gen
	import option_regs_pkg::*;
#(
	parameter int TICK_CYCLES = DTR_TICK_CYCLES
) (
	// clock and reset
	input  wire logic clk,
	input  wire logic resetn,
	// control
	input  wire logic restart,
	// tick out
	output logic      tick_q
);

	localparam int CW = $clog2(TICK_CYCLES);

	// a divider of one cycle would tick every cycle and break the restart timing
	if (TICK_CYCLES < 2) begin : g_bad_tick
		$error("dtr_tick_gen: TICK_CYCLES must be at least 2");
	end

	logic [CW-1:0] div_q;
	logic [CW-1:0] div_d;
	logic          tick_d;

	// ****************************************************************
	// divider
	// ****************************************************************
	// restart holds the divider at zero so a new change starts a full tick
	always_comb begin
		div_d  = div_q;
		tick_d = 1'b0;
		if (restart) begin
			div_d = '0;
		end else if (div_q == CW'(TICK_CYCLES - 1)) begin
			div_d  = '0;
			tick_d = 1'b1;
		end else begin
			div_d = div_q + CW'(1);
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			div_q  <= '0;
			tick_q <= 1'b0;
		end else begin
			div_q  <= div_d;
			tick_q <= tick_d;
		end
	end

endmodule

// ==== test/option_regs_dtr_filter_asserts.sv ====
// checker: port-level assertions for the option bank
`timescale 1ns/1ps
module option_regs_dtr_filter_asserts
	import option_regs_pkg::*;
(
	// clock and reset
	input wire logic            clk,
	input wire logic            resetn,
	// requests
	input wire logic            reg_wr_valid,
	input wire reg_write_t      reg_wr,
	input wire logic            field_valid,
	input wire field_write_t    field_wr,
	input wire logic            factory_restore,
	input wire logic            rd_valid,
	input wire logic [7:0]      rd_regnum,
	// answers
	input wire logic            rd_done_q,
	input wire logic            rd_hit_q,
	input wire logic [7:0]      rd_data_q,
	input wire logic            cmd_done_q,
	input wire logic            cmd_err_q,
	// options and dtr
	input wire speaker_result_t speaker_result_q,
	input wire line_options_t   line_options_q,
	input wire installation_t   installation_q,
	input wire logic [7:0]      dtr_time_q,
	input wire logic            speed_valid_q,
	input wire logic            dtr_in,
	input wire logic            dtr_ack_q,
	input wire logic            dtr_change_q
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	// ****************************************************************
	// address decode helpers
	// ****************************************************************
	wire wr_map = reg_wr.regnum >= REG_SPEAKER_RESULT && reg_wr.regnum <= REG_DTR_TIME;
	wire rd_map = rd_regnum >= REG_SPEAKER_RESULT && rd_regnum <= REG_DTR_TIME;
	wire wr_go  = reg_wr_valid && !factory_restore;
	// ****************************************************************
	// assertions
	// ****************************************************************
	chk_read_miss: assert property (rd_valid && !rd_map |=> rd_done_q && !rd_hit_q && rd_data_q == 8'h00)
		else $error("unmapped read answered wrongly");
	chk_read_hit: assert property (rd_valid && rd_map |=> rd_done_q && rd_hit_q)
		else $error("mapped read not answered");
	chk_cmd_answer: assert property ((reg_wr_valid || field_valid || factory_restore) |=> cmd_done_q != cmd_err_q)
		else $error("command without one answer");
	chk_unmapped_write: assert property (wr_go && !wr_map |=> cmd_err_q && $stable(speaker_result_q) && $stable(dtr_time_q))
		else $error("unmapped write changed state");
	chk_dtr_time_wr: assert property (wr_go && reg_wr.regnum == REG_DTR_TIME |=> dtr_time_q == $past(reg_wr.value))
		else $error("filter time not stored");
	chk_restore_vals: assert property (factory_restore |=> speaker_result_q == 8'h76 && line_options_q == 8'h07 && dtr_time_q == 8'h05)
		else $error("factory values wrong");
	chk_restore_keep: assert property (factory_restore |=> $stable(installation_q))
		else $error("restore touched installation");
	chk_bit3_zero: assert property (installation_q.unused == 1'b0)
		else $error("installation bit 3 set");
	chk_speed_flag: assert property (speed_valid_q == (line_options_q.speed != SPEED_UNUSED_LO && line_options_q.speed != SPEED_UNUSED_HI))
		else $error("speed flag wrong");
	chk_change_pulse: assert property (dtr_change_q == (dtr_ack_q != $past(dtr_ack_q)))
		else $error("change pulse not with ack change");
	chk_ack_cause: assert property ($changed(dtr_ack_q) |-> $past(dtr_in) == dtr_ack_q)
		else $error("ack moved without lead");
	// main scenarios
	cover property (factory_restore);
	cover property (dtr_change_q && dtr_ack_q);
	cover property (wr_go && !wr_map);
	cover property (factory_restore && reg_wr_valid && field_valid);
endmodule

// ==== test/dte_dtr_model.sv ====
// partner: terminal side model driving the dtr lead
`timescale 1ns/1ps
module dte_dtr_model (
	// clock
	input  wire logic clk,
	// lead level asked for by the sequence
	input  wire logic level_req,
	// dtr lead
	output logic      dtr_in
);
	logic lvl_q;
	// two stages so the lead moves one whole cycle after the request, no race
	initial lvl_q = 1'b0;
	initial dtr_in = 1'b0;
	always @(posedge clk) lvl_q <= level_req;
	always @(negedge clk) dtr_in <= lvl_q;
endmodule

// ==== test/tb.sv ====
// testbench: register access, factory restore and dtr filter checks
`timescale 1ns/1ps
module tb;
	import option_regs_pkg::*;
	localparam int TICKS = 4;
	logic            clk, resetn, reg_wr_valid, field_valid, factory_restore, rd_valid;
	logic            level_req, rd_done_q, rd_hit_q, cmd_done_q, cmd_err_q;
	logic            speed_valid_q, dtr_in, dtr_ack_q, dtr_change_q;
	logic [7:0]      rd_regnum, rd_data_q, dtr_time_q;
	reg_write_t      reg_wr;
	field_write_t    field_wr;
	speaker_result_t speaker_result_q;
	line_options_t   line_options_q;
	installation_t   installation_q;
	int              bad_count, n_compared, cycles, n;

	option_regs_dtr_filter #(.TICK_CYCLES(TICKS)) i_option_regs_dtr_filter (
		.clk(clk), .resetn(resetn), .reg_wr_valid(reg_wr_valid), .reg_wr(reg_wr),
		.field_valid(field_valid), .field_wr(field_wr), .factory_restore(factory_restore),
		.rd_valid(rd_valid), .rd_regnum(rd_regnum), .rd_done_q(rd_done_q), .rd_hit_q(rd_hit_q),
		.rd_data_q(rd_data_q), .cmd_done_q(cmd_done_q), .cmd_err_q(cmd_err_q),
		.speaker_result_q(speaker_result_q), .line_options_q(line_options_q),
		.installation_q(installation_q), .dtr_time_q(dtr_time_q), .speed_valid_q(speed_valid_q),
		.dtr_in(dtr_in), .dtr_ack_q(dtr_ack_q), .dtr_change_q(dtr_change_q));
	dte_dtr_model i_dte_dtr_model (.clk(clk), .level_req(level_req), .dtr_in(dtr_in));

	// ****************************************************************
	// clock, timeout and shared tasks
	// ****************************************************************
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// run is well under a thousand cycles; a hang is cut here
	always @(posedge clk) begin
		cycles++;
		if (cycles == 4000) begin
			bad_count++;
			print_verdict();
		end
	end
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// kind 0 register write, 1 field command, 2 factory restore
	task automatic cmd(input int kind, input logic [7:0] a, input logic [7:0] b, input logic err);
		@(negedge clk);
		reg_wr_valid = (kind == 0);
		field_valid = (kind == 1);
		factory_restore = (kind == 2);
		reg_wr = '{a, b};
		field_wr = '{field_cmd_t'(a[2:0]), b};
		@(negedge clk);
		{reg_wr_valid, field_valid, factory_restore} = 3'b000;
		chk({7'h00, cmd_err_q}, {7'h00, err});
		chk({7'h00, cmd_done_q}, {7'h00, !err});
	endtask
	task automatic rd(input logic [7:0] r, input logic hit, input logic [7:0] d);
		@(negedge clk);
		rd_valid = 1'b1;
		rd_regnum = r;
		@(negedge clk);
		rd_valid = 1'b0;
		chk({7'h00, rd_done_q}, 8'h01);
		chk({7'h00, rd_hit_q}, {7'h00, hit});
		chk(rd_data_q, d);
	endtask
	// counts cycles from the lead change to the acknowledge pulse
	task automatic dtr_wait(input logic lvl, input int lo, input int hi);
		level_req = lvl;
		n = 0;
		while (dtr_in !== lvl) @(negedge clk);
		while (dtr_change_q !== 1'b1 && n < 100) begin
			@(negedge clk);
			n++;
		end
		chk({7'h00, n >= lo && n <= hi}, 8'h01);
		chk({7'h00, dtr_ack_q}, {7'h00, lvl});
	endtask
	task automatic print_verdict();
		$display("compared %0d, mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		{resetn, reg_wr_valid, field_valid, factory_restore, rd_valid, level_req} = 6'h00;
		reg_wr = '0;
		field_wr = '{CMD_VOLUME, 8'h00};
		rd_regnum = 8'h00;
		{bad_count, n_compared, cycles} = {32'd0, 32'd0, 32'd0};
		repeat (5) @(negedge clk);
		resetn = 1'b1;
		rd(REG_SPEAKER_RESULT, 1'b1, 8'h76);
		rd(REG_LINE_OPTIONS, 1'b1, 8'h07);
		rd(REG_INSTALLATION, 1'b1, 8'h00);
		rd(REG_DTR_TIME, 1'b1, 8'h05);
		// field commands, with out-of-range arguments refused
		cmd(1, CMD_VOLUME, 8'h03, 1'b0);
		cmd(1, CMD_SPEAKER_CTRL, 8'h00, 1'b0);
		cmd(1, CMD_RESULT_CODE, 8'h05, 1'b0);
		cmd(1, CMD_DIAL_RATIO, 8'h01, 1'b0);
		cmd(1, CMD_VOLUME, 8'h04, 1'b1);
		cmd(1, CMD_RESULT_CODE, 8'h08, 1'b1);
		cmd(1, CMD_SPEAKER_CTRL, 8'h04, 1'b1);
		cmd(1, CMD_DIAL_RATIO, 8'h02, 1'b1);
		cmd(1, 8'h06, 8'h00, 1'b1);
		rd(REG_SPEAKER_RESULT, 1'b1, 8'hd3);
		cmd(1, CMD_REMOTE_LOOP, 8'h00, 1'b0);
		cmd(1, CMD_GUARD_TONE, 8'h02, 1'b0);
		cmd(1, CMD_REMOTE_LOOP, 8'h02, 1'b1);
		cmd(1, CMD_GUARD_TONE, 8'h04, 1'b1);
		rd(REG_LINE_OPTIONS, 1'b1, 8'h86);
		// every speed code and every parity
		for (int i = 0; i < 8; i++) begin
			cmd(0, REG_LINE_OPTIONS, {2'b00, 2'(i), 3'(i), 1'b1}, 1'b0);
			chk({5'h00, line_options_q.speed}, 8'(i));
			chk({6'h00, line_options_q.parity}, 8'(i % 4));
			chk({7'h00, speed_valid_q}, {7'h00, i != 1 && i != 7});
		end
		// any byte accepted
		cmd(0, REG_SPEAKER_RESULT, 8'hff, 1'b0);
		rd(REG_SPEAKER_RESULT, 1'b1, 8'hff);
		cmd(0, REG_LINE_OPTIONS, 8'hff, 1'b0);
		rd(REG_LINE_OPTIONS, 1'b1, 8'hff);
		cmd(0, REG_DTR_TIME, 8'hff, 1'b0);
		rd(REG_DTR_TIME, 1'b1, 8'hff);
		// installation only through direct writes; bit 3 never sticks
		cmd(0, REG_INSTALLATION, 8'hff, 1'b0);
		rd(REG_INSTALLATION, 1'b1, 8'hf7);
		chk(installation_q, 8'hf7);
		cmd(0, REG_INSTALLATION, 8'h49, 1'b0);
		chk(installation_q, 8'h41);
		cmd(0, 8'h1a, 8'h12, 1'b1);
		rd(8'h1a, 1'b0, 8'h00);
		// factory restore keeps installation
		cmd(2, 8'h00, 8'h00, 1'b0);
		rd(REG_INSTALLATION, 1'b1, 8'h41);
		rd(REG_SPEAKER_RESULT, 1'b1, 8'h76);
		rd(REG_LINE_OPTIONS, 1'b1, 8'h07);
		rd(REG_DTR_TIME, 1'b1, 8'h05);
		// same-cycle requests: restore beats write, write beats field command
		@(negedge clk);
		{reg_wr_valid, field_valid, factory_restore} = 3'b111;
		reg_wr = '{REG_DTR_TIME, 8'h33};
		field_wr = '{CMD_VOLUME, 8'h00};
		@(negedge clk);
		{reg_wr_valid, field_valid, factory_restore} = 3'b110;
		chk(dtr_time_q, 8'h05);
		@(negedge clk);
		{reg_wr_valid, field_valid, factory_restore} = 3'b000;
		chk(dtr_time_q, 8'h33);
		chk(speaker_result_q, 8'h76);
		cmd(0, REG_DTR_TIME, 8'h05, 1'b0);
		// two short highs split by a dip: restart means no acknowledge
		level_req = 1'b1;
		repeat (15) @(negedge clk);
		level_req = 1'b0;
		repeat (2) @(negedge clk);
		level_req = 1'b1;
		repeat (15) @(negedge clk);
		level_req = 1'b0;
		repeat (30) @(negedge clk);
		chk({7'h00, dtr_ack_q}, 8'h00);
		dtr_wait(1'b1, 5 * TICKS, 5 * TICKS + 6);
		cmd(0, REG_DTR_TIME, 8'h02, 1'b0);
		dtr_wait(1'b0, 2 * TICKS, 2 * TICKS + 6);
		// second reset mid-run puts installation back to zero
		resetn = 1'b0;
		repeat (2) @(negedge clk);
		resetn = 1'b1;
		rd(REG_INSTALLATION, 1'b1, 8'h00);
		print_verdict();
	end
endmodule

bind option_regs_dtr_filter option_regs_dtr_filter_asserts i_option_regs_dtr_filter_asserts (
	.clk(clk), .resetn(resetn), .reg_wr_valid(reg_wr_valid), .reg_wr(reg_wr),
	.field_valid(field_valid), .field_wr(field_wr), .factory_restore(factory_restore),
	.rd_valid(rd_valid), .rd_regnum(rd_regnum), .rd_done_q(rd_done_q), .rd_hit_q(rd_hit_q),
	.rd_data_q(rd_data_q), .cmd_done_q(cmd_done_q), .cmd_err_q(cmd_err_q),
	.speaker_result_q(speaker_result_q), .line_options_q(line_options_q),
	.installation_q(installation_q), .dtr_time_q(dtr_time_q), .speed_valid_q(speed_valid_q),
	.dtr_in(dtr_in), .dtr_ack_q(dtr_ack_q), .dtr_change_q(dtr_change_q));
